// ---- shared/flash_prog_consts.svh ----
// Offsets, field positions, opcodes and times of the programming host
`ifndef FLASH_PROG_CONSTS_SVH
`define FLASH_PROG_CONSTS_SVH
// Software register offsets
`define REG_CTRL       8'h00
`define REG_ADDR       8'h04
`define REG_WDATA      8'h08
`define REG_STATUS     8'h0c
// Control register fields
`define CTRL_START     0
`define CTRL_OP_LO     1
`define CTRL_OP_HI     2
`define CTRL_MSEL_LO   4
`define CTRL_MSEL_HI   7
`define CTRL_SESSION   8
`define CTRL_PARALLEL  9
`define CTRL_SCMD_LO   12
`define CTRL_SCMD_HI   14
// Status register fields
`define STAT_BUSY      0
`define STAT_READY     1
`define STAT_ENABLED   2
`define STAT_RD_LO     8
`define STAT_RD_HI     15
// Serial instruction bytes
`define SPI_PREFIX     8'hac
`define SPI_ENABLE2    8'h53
`define SPI_ERASE2     8'h04
`define SPI_RD_CODE    3'h1
`define SPI_WR_CODE    3'h2
`define SPI_RD_DATA    3'h5
`define SPI_WR_DATA    3'h6
`define SPI_BITS       5'h18
// Times in ns
`define CLK_NS         10
`define SETTLE_NS      1000
`define PROG_PULSE_NS  1000
`define ERASE_PULSE_NS 10000000
`endif

// ---- shared/flash_prog_pkg.sv ----
// Types of the flash and EEPROM programming host
package flash_prog_pkg;
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    S_IDLE   = 6'h01,
    S_SHIFT  = 6'h02,
    S_SETTLE = 6'h04,
    S_PULSE  = 6'h08,
    S_WAIT   = 6'h10,
    S_READ   = 6'h20
  } state_t;
  // Operation kinds, serial and parallel
  typedef enum logic [1:0] {
    OP_SERIAL = 2'h0,
    OP_PREAD  = 2'h1,
    OP_PWRITE = 2'h2,
    OP_PLONG  = 2'h3
  } op_t;
  // Serial instructions
  typedef enum logic [2:0] {
    SC_ENABLE = 3'h0,
    SC_ERASE  = 3'h1,
    SC_RDCODE = 3'h2,
    SC_WRCODE = 3'h3,
    SC_RDDATA = 3'h4,
    SC_WRDATA = 3'h5
  } scmd_t;
  // Parallel control pins of the device
  typedef struct packed {
    logic        vpp_en;
    logic        program_store_select_n;
    logic        prog_n;
    logic [3:0]  mode_sel;
    logic [13:0] addr;
  } par_pins_t;
endpackage

// ---- rtl/flash_prog_host.sv ----
// Host controller that programs the flash and EEPROM over serial or parallel pins
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "flash_prog_consts.svh"
module flash_prog_host #(
  parameter int SCK_HALF  = 80,
  parameter int ERASE_CYC = `ERASE_PULSE_NS / `CLK_NS
) (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RST_N,
  // Software register port
  input  wire logic [7:0]              REG_ADDR,
  input  wire logic [31:0]             REG_WDATA,
  input  wire logic                    REG_WR,
  input  wire logic                    REG_RD,
  output logic [31:0]                  REG_RDATA,
  // Serial programming pins
  output logic                         DEV_RST,
  output logic                         DEV_SCK,
  output logic                         DEV_MOSI,
  input  wire logic                    DEV_MISO,
  // Parallel programming pins
  output flash_prog_pkg::par_pins_t    DEV_PAR,
  output logic [7:0]                   DEV_DATA_O,
  output logic                         DEV_DATA_OE,
  input  wire logic [7:0]              DEV_DATA_I,
  input  wire logic                    DEV_READY
);
  localparam int SETTLE_CYC = (`SETTLE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int PROG_CYC   = (`PROG_PULSE_NS + `CLK_NS - 1) / `CLK_NS;

  flash_prog_pkg::state_t    state_q;
  flash_prog_pkg::op_t       op_q;
  flash_prog_pkg::scmd_t     scmd_q;
  flash_prog_pkg::par_pins_t par_q;
  logic        session_q;
  logic        parallel_q;
  logic        enabled_q;
  logic [13:0] addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rx_q;
  logic [23:0] sh_q;
  logic [4:0]  bits_q;
  logic [31:0] cnt_q;
  logic        sck_q;
  logic        mosi_q;
  logic        oe_q;
  logic [31:0] rd_q;
  logic        miso_s1;
  logic        miso_s2;
  logic        rdy_s1;
  logic        rdy_s2;
  logic [7:0]  din_s1;
  logic [7:0]  din_s2;

  // Builds the three instruction bytes, MSB first
  function automatic logic [23:0] build_instr(input flash_prog_pkg::scmd_t c, input logic [13:0] a,
                                              input logic [7:0] d);
    logic [23:0] r;
    r = {`SPI_PREFIX, `SPI_ENABLE2, 8'h00};
    case (c)
      flash_prog_pkg::SC_ERASE:  r = {`SPI_PREFIX, 5'h00, 3'h4, 8'h00};
      flash_prog_pkg::SC_RDCODE: r = {a[12:8], `SPI_RD_CODE, a[7:0], 8'h00};
      flash_prog_pkg::SC_WRCODE: r = {a[12:8], `SPI_WR_CODE, a[7:0], d};
      flash_prog_pkg::SC_RDDATA: r = {2'h0, a[10:8], `SPI_RD_DATA, a[7:0], 8'h00};
      flash_prog_pkg::SC_WRDATA: r = {2'h0, a[10:8], `SPI_WR_DATA, a[7:0], d};
      default:                   r = {`SPI_PREFIX, `SPI_ENABLE2, 8'h00};
    endcase
    return r;
  endfunction

  // Command decode
  wire                        wr_ctrl  = REG_WR && (REG_ADDR == `REG_CTRL);
  wire                        idle     = (state_q == flash_prog_pkg::S_IDLE);
  wire                        start    = wr_ctrl && idle && REG_WDATA[`CTRL_START];
  wire flash_prog_pkg::op_t   new_op   = flash_prog_pkg::op_t'(REG_WDATA[`CTRL_OP_HI:`CTRL_OP_LO]);
  wire flash_prog_pkg::scmd_t new_scmd = flash_prog_pkg::scmd_t'(REG_WDATA[`CTRL_SCMD_HI:`CTRL_SCMD_LO]);
  wire [23:0]                 new_instr = build_instr(new_scmd, addr_q, wdata_q);
  wire                        go_ser   = start && session_q && !parallel_q && (new_op == flash_prog_pkg::OP_SERIAL)
                                         && (enabled_q || new_scmd == flash_prog_pkg::SC_ENABLE);
  wire                        go_par   = start && session_q && parallel_q && (new_op != flash_prog_pkg::OP_SERIAL);
  wire                        is_read  = (new_op == flash_prog_pkg::OP_PREAD);
  wire [3:0]                  new_msel = REG_WDATA[`CTRL_MSEL_HI:`CTRL_MSEL_LO];
  wire                        tick     = (cnt_q == 32'(SCK_HALF - 1));
  // Long strobe serves chip erase before any parallel rewrite
  wire [31:0]                 pulse_len = (op_q == flash_prog_pkg::OP_PLONG) ? 32'(ERASE_CYC) : 32'(PROG_CYC);
  wire [31:0]                 status   = {16'h0000, rdata_q, 5'h00, enabled_q, rdy_s2, !idle};

  // Read mux
  wire [31:0] rd_val = (REG_ADDR == `REG_CTRL)   ? {30'h0, parallel_q, session_q} << `CTRL_SESSION :
                       (REG_ADDR == `REG_ADDR)   ? {18'h0, addr_q} :
                       (REG_ADDR == `REG_WDATA)  ? {24'h0, wdata_q} :
                       (REG_ADDR == `REG_STATUS) ? status : 32'h0;

  // Two-stage synchronisers for device pins
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      rdy_s1  <= 1'b0;
      rdy_s2  <= 1'b0;
      din_s1  <= 8'h00;
      din_s2  <= 8'h00;
    end
    else
    begin
      miso_s1 <= DEV_MISO;
      miso_s2 <= miso_s1;
      rdy_s1  <= DEV_READY;
      rdy_s2  <= rdy_s1;
      din_s1  <= DEV_DATA_I;
      din_s2  <= din_s1;
    end
  end

  // Register writes and read data
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      addr_q  <= 14'h0000;
      wdata_q <= 8'h00;
      rd_q    <= 32'h0;
    end
    else
    begin
      if (REG_WR && REG_ADDR == `REG_ADDR && idle)
        addr_q <= REG_WDATA[13:0];
      if (REG_WR && REG_ADDR == `REG_WDATA && idle)
        wdata_q <= REG_WDATA[7:0];
      rd_q <= REG_RD ? rd_val : 32'h0;
    end
  end

  // Sequencer for serial transfers and parallel strobes
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q    <= flash_prog_pkg::S_IDLE;
      op_q       <= flash_prog_pkg::OP_SERIAL;
      scmd_q     <= flash_prog_pkg::SC_ENABLE;
      par_q      <= '{vpp_en: 1'b0, program_store_select_n: 1'b1, prog_n: 1'b1, mode_sel: 4'h0, addr: 14'h0000};
      session_q  <= 1'b0;
      parallel_q <= 1'b0;
      enabled_q  <= 1'b0;
      rdata_q    <= 8'h00;
      rx_q       <= 8'h00;
      sh_q       <= 24'h000000;
      bits_q     <= 5'h00;
      cnt_q      <= 32'h0;
      sck_q      <= 1'b0;
      mosi_q     <= 1'b0;
      oe_q       <= 1'b0;
    end
    else
    begin
      case (state_q)
        flash_prog_pkg::S_IDLE:
        begin
          cnt_q <= 32'h0;
          if (wr_ctrl)
          begin
            session_q  <= REG_WDATA[`CTRL_SESSION];
            parallel_q <= REG_WDATA[`CTRL_PARALLEL];
            par_q.vpp_en                 <= REG_WDATA[`CTRL_SESSION] && REG_WDATA[`CTRL_PARALLEL];
            par_q.program_store_select_n <= !(REG_WDATA[`CTRL_SESSION] && REG_WDATA[`CTRL_PARALLEL]);
            if (!REG_WDATA[`CTRL_SESSION])
              enabled_q <= 1'b0;
          end
          if (go_ser)
          begin
            scmd_q  <= new_scmd;
            sh_q    <= new_instr;
            mosi_q  <= new_instr[23];
            bits_q  <= 5'h00;
            state_q <= flash_prog_pkg::S_SHIFT;
          end
          else if (go_par)
          begin
            op_q           <= new_op;
            par_q.mode_sel <= is_read ? (new_msel & 4'hd) : new_msel;
            par_q.addr     <= addr_q;
            oe_q           <= !is_read;
            state_q        <= flash_prog_pkg::S_SETTLE;
          end
        end
        flash_prog_pkg::S_SHIFT:
        begin
          cnt_q <= tick ? 32'h0 : cnt_q + 32'h1;
          if (tick)
          begin
            sck_q <= !sck_q;
            if (!sck_q)
            begin
              rx_q   <= {rx_q[6:0], miso_s2};
              bits_q <= bits_q + 5'h01;
            end
            else if (bits_q == `SPI_BITS)
            begin
              rdata_q <= rx_q;
              if (scmd_q == flash_prog_pkg::SC_ENABLE)
                enabled_q <= 1'b1;
              state_q <= flash_prog_pkg::S_IDLE;
            end
            else
            begin
              sh_q   <= {sh_q[22:0], 1'b0};
              mosi_q <= sh_q[22];
            end
          end
        end
        flash_prog_pkg::S_SETTLE:
        begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == 32'(SETTLE_CYC - 1))
          begin
            cnt_q <= 32'h0;
            if (op_q == flash_prog_pkg::OP_PREAD)
              state_q <= flash_prog_pkg::S_READ;
            else
            begin
              par_q.prog_n <= 1'b0;
              state_q      <= flash_prog_pkg::S_PULSE;
            end
          end
        end
        flash_prog_pkg::S_PULSE:
        begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == pulse_len - 32'h1)
          begin
            par_q.prog_n <= 1'b1;
            cnt_q        <= 32'h0;
            state_q      <= flash_prog_pkg::S_WAIT;
          end
        end
        flash_prog_pkg::S_WAIT:
        begin
          // Let busy assert before trusting ready
          if (cnt_q != 32'(SETTLE_CYC))
            cnt_q <= cnt_q + 32'h1;
          else if (rdy_s2)
          begin
            oe_q    <= 1'b0;
            state_q <= flash_prog_pkg::S_IDLE;
          end
        end
        flash_prog_pkg::S_READ:
        begin
          rdata_q <= din_s2;
          state_q <= flash_prog_pkg::S_IDLE;
        end
        default:
          state_q <= flash_prog_pkg::S_IDLE;
      endcase
    end
  end

  // Outputs straight from flops
  assign REG_RDATA   = rd_q;
  assign DEV_RST     = session_q;
  assign DEV_SCK     = sck_q;
  assign DEV_MOSI    = mosi_q;
  assign DEV_PAR     = par_q;
  assign DEV_DATA_O  = wdata_q;
  assign DEV_DATA_OE = oe_q;

  // Assertion helpers: cycles since last shift-clock edge, strobe low time
  logic [31:0] sck_age_q;
  logic [31:0] low_q;
  logic        sck_prev_q;
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sck_age_q  <= 32'h0;
      low_q      <= 32'h0;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      sck_prev_q <= sck_q;
      sck_age_q  <= (sck_q != sck_prev_q) ? 32'h1 : sck_age_q + 32'h1;
      low_q     <= par_q.prog_n ? 32'h0 : low_q + 32'h1;
    end
  end

  property p_sck_rate;
    @(posedge CLK) disable iff (!RST_N) $changed(sck_q) |-> $past(sck_age_q) >= 32'(SCK_HALF - 1);
  endproperty
  a_sck_rate: assert property (p_sck_rate) else $error("shift clock too fast");

  property p_three_bytes;
    @(posedge CLK) disable iff (!RST_N)
      $fell(state_q == flash_prog_pkg::S_SHIFT) |-> $past(bits_q) == `SPI_BITS && !sck_q;
  endproperty
  a_three_bytes: assert property (p_three_bytes) else $error("serial frame not 24 bits");

  property p_mosi_on_fall;
    @(posedge CLK) disable iff (!RST_N)
      $past(state_q == flash_prog_pkg::S_SHIFT) && $changed(mosi_q) |-> $fell(sck_q);
  endproperty
  a_mosi_on_fall: assert property (p_mosi_on_fall) else $error("data changed off falling edge");

  property p_erase_bytes;
    @(posedge CLK) disable iff (!RST_N)
      go_ser && new_scmd == flash_prog_pkg::SC_ERASE |=> sh_q[23:16] == `SPI_PREFIX && sh_q[10:8] == 3'h4;
  endproperty
  a_erase_bytes: assert property (p_erase_bytes) else $error("bad erase instruction");

  property p_enable_first;
    @(posedge CLK) disable iff (!RST_N)
      $rose(state_q == flash_prog_pkg::S_SHIFT) |-> enabled_q || scmd_q == flash_prog_pkg::SC_ENABLE;
  endproperty
  a_enable_first: assert property (p_enable_first) else $error("instruction before enable");

  property p_verify_line;
    @(posedge CLK) disable iff (!RST_N)
      state_q == flash_prog_pkg::S_READ |-> !par_q.mode_sel[1] && !oe_q;
  endproperty
  a_verify_line: assert property (p_verify_line) else $error("verify with second line high");

  property p_strobe_mode;
    @(posedge CLK) disable iff (!RST_N)
      !par_q.prog_n |-> par_q.vpp_en && !par_q.program_store_select_n && DEV_RST;
  endproperty
  a_strobe_mode: assert property (p_strobe_mode) else $error("strobe outside parallel mode");

  property p_long_pulse;
    @(posedge CLK) disable iff (!RST_N)
      $rose(par_q.prog_n) && op_q == flash_prog_pkg::OP_PLONG |-> $past(low_q) == 32'(ERASE_CYC - 1);
  endproperty
  a_long_pulse: assert property (p_long_pulse) else $error("erase strobe wrong length");

  property p_write_waits;
    @(posedge CLK) disable iff (!RST_N)
      $rose(par_q.prog_n) |-> state_q == flash_prog_pkg::S_WAIT ##1 state_q == flash_prog_pkg::S_WAIT;
  endproperty
  a_write_waits: assert property (p_write_waits) else $error("no wait after strobe");

  c_serial: cover property (@(posedge CLK) disable iff (!RST_N) $fell(state_q == flash_prog_pkg::S_SHIFT));
  c_pwrite: cover property (@(posedge CLK) disable iff (!RST_N)
                            $fell(state_q == flash_prog_pkg::S_WAIT) && op_q == flash_prog_pkg::OP_PWRITE);
  c_pread:  cover property (@(posedge CLK) disable iff (!RST_N) state_q == flash_prog_pkg::S_READ);
  c_erase:  cover property (@(posedge CLK) disable iff (!RST_N)
                            $rose(par_q.prog_n) && op_q == flash_prog_pkg::OP_PLONG);
endmodule

// ---- verif/prog_dev_model.sv ----
// Behavioural model of the flash and EEPROM device in programming mode
`timescale 1ns/10ps
module prog_dev_model #(
  parameter logic [7:0] SIG_MAKER = 8'h5c, // Arbitrary value
  parameter logic [7:0] SIG_PART  = 8'h3d  // Arbitrary value
) (
  // Oscillator
  input  wire logic                      CLK,
  // Pins from the host
  input  wire logic                      DEV_RST,
  input  wire logic                      DEV_SCK,
  input  wire logic                      DEV_MOSI,
  input  wire flash_prog_pkg::par_pins_t DEV_PAR,
  input  wire logic [7:0]                DEV_DATA_O,
  input  wire logic                      DEV_DATA_OE,
  // Pins to the host
  output logic                           DEV_MISO,
  output logic [7:0]                     DEV_DATA_I,
  output logic                           DEV_READY
);
  logic [7:0]  mem [0:10239];
  logic [23:0] sh;
  logic [7:0]  rd;
  logic [7:0]  pd;
  logic [7:0]  last_d;
  logic [13:0] last_a;
  logic [2:0]  lb       = 3'h7; // Lock bits one to three, 1 = unprogrammed
  logic        en       = 1'b0;
  logic        fuse_dis = 1'b0; // Serial path enabled as shipped
  int          cnt      = 0;
  time         wr_end   = 0;
  time         er_end   = 0;
  wire         par      = DEV_RST && DEV_PAR.vpp_en && !DEV_PAR.program_store_select_n;
  // Erase both arrays to all ones, locks cleared
  task automatic erase_all;
    for (int i = 0; i < 10240; i++)
      mem[i] = 8'hff;
    lb = 3'h7;
  endtask
  // Byte write, timed by the device itself
  task automatic wr_mem(input logic [13:0] a, input logic [7:0] d, input time t);
    mem[a] = d;
    last_a = a;
    last_d = d;
    wr_end = $time + t;
  endtask
  // Byte read with erase, lock and polling effects
  function automatic logic [7:0] rd_mem(input logic [13:0] a);
    if ($time < er_end)
      return 8'h00;
    if (lb[1:0] != 2'h3)
      return 8'h00; // Verify disabled
    if ($time < wr_end && a == last_a)
      return {~last_d[7], mem[a][6:0]};
    return mem[a];
  endfunction
  initial
  begin
    DEV_MISO = 1'b0;
    DEV_READY = 1'b1;
    erase_all;
  end
  // Three-byte frames, MSB first, taken on rising shift clock
  always @(posedge DEV_SCK or negedge DEV_RST)
  begin
    if (!DEV_RST)
    begin
      cnt = 0;
      en = 1'b0; // Session ends
    end
    else if (!fuse_dis)
    begin
      sh = {sh[22:0], DEV_MOSI};
      cnt = cnt + 1;
      if (cnt == 16)
        rd = (sh[10:8] == 3'h5) ? rd_mem({3'h4, sh[13:11], sh[7:0]}) : rd_mem({1'b0, sh[15:11], sh[7:0]});
      if (cnt == 24)
      begin
        cnt = 0;
        if (sh[23:8] == 16'hac53)
          en = 1'b1;
        else if (en && sh[23:16] == 8'hac && sh[10:8] == 3'h4)
        begin
          erase_all;
          er_end = $time + 100000;
        end
        else if (en && sh[18:16] == 3'h2)
          wr_mem({1'b0, sh[23:19], sh[15:8]}, sh[7:0], 45000);
        else if (en && sh[18:16] == 3'h6 && sh[23:22] == 2'h0)
          wr_mem({3'h4, sh[21:19], sh[15:8]}, sh[7:0], 45000);
      end
    end
  end
  // Read data shifted out on falling edge, else a changing pattern
  always @(negedge DEV_SCK)
    DEV_MISO = (cnt >= 16) ? rd[23 - cnt] : ~DEV_MISO;
  // Parallel operation at end of program strobe, busy shown low
  always @(posedge DEV_PAR.prog_n)
    if (par)
    begin
      case (DEV_PAR.mode_sel)
        4'he: wr_mem(DEV_PAR.addr, DEV_DATA_O, 3000);
        4'h1: erase_all;
        4'h5: lb = lb & {DEV_DATA_O[5], DEV_DATA_O[6], DEV_DATA_O[7]};
        4'ha: fuse_dis = DEV_DATA_O[0];
        default: ;
      endcase
      DEV_READY = 1'b0;
      #3000;
      DEV_READY = 1'b1;
    end
  // Parallel read data, signature and lock readout
  always @(posedge CLK)
    case (DEV_PAR.mode_sel)
      4'hc: pd <= rd_mem(DEV_PAR.addr);
      4'h0: pd <= (DEV_PAR.addr == 14'h30) ? SIG_MAKER : ((DEV_PAR.addr == 14'h31) ? SIG_PART : 8'hff);
      4'h3: pd <= {5'h1f, lb[0], lb[1], lb[2]};
      default: pd <= 8'hff;
    endcase
  assign DEV_DATA_I = (par && !DEV_DATA_OE) ? pd : ~DEV_DATA_O;
endmodule

// ---- verif/tb_flash_prog_host.sv ----
// Self-checking bench of the flash and EEPROM programming host
`timescale 1ns/10ps
`include "flash_prog_consts.svh"
module tb_flash_prog_host;
  localparam int         ERASE_CYC = 200;
  localparam logic [7:0] SIG_MAKER = 8'h5c; // Arbitrary value
  localparam logic [7:0] SIG_PART  = 8'h3d; // Arbitrary value
  logic                      clk        = 1'b0;
  logic                      rst_n      = 1'b0;
  logic                      reg_wr     = 1'b0;
  logic                      reg_rd     = 1'b0;
  logic [7:0]                reg_addr   = 8'h00;
  logic [31:0]               reg_wdata  = 32'h0;
  logic [31:0]               reg_rdata;
  logic                      dev_rst;
  logic                      dev_sck;
  logic                      dev_mosi;
  logic                      dev_miso;
  logic                      dev_data_oe;
  logic                      dev_ready;
  logic [7:0]                dev_data_o;
  logic [7:0]                dev_data_i;
  flash_prog_pkg::par_pins_t dev_par;
  int                        n_errors   = 0;
  int                        n_compared = 0;
  int                        cycles     = 0;
  int                        n;
  logic [7:0]                b;
  logic [31:0]               w;
  flash_prog_host #(.SCK_HALF(80), .ERASE_CYC(ERASE_CYC)) u_flash_prog_host (
    .CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .DEV_RST(dev_rst), .DEV_SCK(dev_sck), .DEV_MOSI(dev_mosi),
    .DEV_MISO(dev_miso), .DEV_PAR(dev_par), .DEV_DATA_O(dev_data_o), .DEV_DATA_OE(dev_data_oe),
    .DEV_DATA_I(dev_data_i), .DEV_READY(dev_ready));
  prog_dev_model #(.SIG_MAKER(SIG_MAKER), .SIG_PART(SIG_PART)) u_prog_dev_model (
    .CLK(clk), .DEV_RST(dev_rst), .DEV_SCK(dev_sck), .DEV_MOSI(dev_mosi), .DEV_PAR(dev_par),
    .DEV_DATA_O(dev_data_o), .DEV_DATA_OE(dev_data_oe), .DEV_MISO(dev_miso), .DEV_DATA_I(dev_data_i),
    .DEV_READY(dev_ready));
  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      n_errors++;
      $display("FAIL %0t timeout", $time);
      end_sim;
    end
  end
  // Verdict and end of run
  task automatic end_sim;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Comparisons
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h0, got}, {7'h0, exp}, what);
  endtask
  // Register port cycles
  task automatic rwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rrd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  function automatic logic [31:0] ctrl(logic st, logic [1:0] op, logic [3:0] ms, logic p, logic [2:0] c);
    return {17'h0, c, 2'h0, p, 1'b1, ms, 1'b0, op, st};
  endfunction
  // Poll busy, return last read byte
  task automatic wait_idle(output logic [7:0] rd);
    int i;
    for (i = 0; i < 20000; i++)
    begin
      rrd(`REG_STATUS, w);
      if (w[`STAT_BUSY] === 1'b0)
        break;
    end
    chk_bit(i < 20000, 1'b1, "operation done");
    rd = w[`STAT_RD_HI:`STAT_RD_LO];
  endtask
  // One serial instruction
  task automatic sop(input logic [2:0] c, input logic [13:0] a, input logic [7:0] d, output logic [7:0] rd);
    rwr(`REG_ADDR, {18'h0, a});
    rwr(`REG_WDATA, {24'h0, d});
    rwr(`REG_CTRL, ctrl(1'b1, 2'h0, 4'h0, 1'b0, c));
    wait_idle(rd);
  endtask
  // Serial reads until the expected byte shows
  task automatic poll(input logic [2:0] c, input logic [13:0] a, input logic [7:0] e);
    for (int i = 0; i < 6; i++)
    begin
      sop(c, a, 8'h00, b);
      if (b === e)
        break;
    end
    chk_byte(b, e, "serial poll");
  endtask
  // One parallel read, port released and second line low
  task automatic pread(input logic [3:0] ms, input logic [13:0] a, input logic [7:0] e);
    rwr(`REG_ADDR, {18'h0, a});
    rwr(`REG_CTRL, ctrl(1'b1, 2'h1, ms, 1'b1, 3'h0));
    @(posedge clk);
    #1;
    chk_bit(dev_par.mode_sel[1] | dev_data_oe, 1'b0, "verify pins");
    wait_idle(b);
    chk_byte(b, e, "parallel read");
  endtask
  // Count cycles until the program strobe reaches a level
  task automatic prog_wait(input logic lvl);
    for (n = 0; n < 2000 && dev_par.prog_n !== lvl; n++)
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic t_reset;
    rrd(`REG_CTRL, w);
    chk_byte(w[7:0], 8'h00, "ctrl reset");
    chk_bit(dev_par === 21'h0c0000 && !dev_rst && !dev_sck && !dev_data_oe, 1'b1, "idle pins");
  endtask
  task automatic t_serial;
    rwr(`REG_CTRL, ctrl(1'b0, 2'h0, 4'h0, 1'b0, 3'h0));
    sop(flash_prog_pkg::SC_ENABLE, 14'h0, 8'h00, b);
    rrd(`REG_STATUS, w);
    chk_bit(w[`STAT_ENABLED] & dev_rst, 1'b1, "enabled");
    poll(flash_prog_pkg::SC_RDCODE, 14'h1fff, 8'hff);
    sop(flash_prog_pkg::SC_WRCODE, 14'h1abc, 8'h3c, b);
    sop(flash_prog_pkg::SC_RDCODE, 14'h1abc, 8'h00, b);
    chk_bit(b[7], 1'b1, "polling msb");
    poll(flash_prog_pkg::SC_RDCODE, 14'h1abc, 8'h3c);
    sop(flash_prog_pkg::SC_WRDATA, 14'h07ff, 8'hc3, b);
    poll(flash_prog_pkg::SC_RDDATA, 14'h07ff, 8'hc3);
    poll(flash_prog_pkg::SC_RDCODE, 14'h07ff, 8'hff);
    sop(flash_prog_pkg::SC_ERASE, 14'h0, 8'h00, b);
    sop(flash_prog_pkg::SC_RDCODE, 14'h1abc, 8'h00, b);
    chk_byte(b, 8'h00, "read in erase");
    poll(flash_prog_pkg::SC_RDCODE, 14'h1abc, 8'hff);
  endtask
  task automatic t_refuse;
    rwr(`REG_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk_bit(dev_rst, 1'b0, "session end");
    rwr(`REG_CTRL, ctrl(1'b0, 2'h0, 4'h0, 1'b0, 3'h0));
    rwr(`REG_CTRL, ctrl(1'b1, 2'h0, 4'h0, 1'b0, flash_prog_pkg::SC_WRCODE));
    rrd(`REG_STATUS, w);
    chk_byte(w[7:0] & 8'h05, 8'h00, "refused");
  endtask
  task automatic t_parallel;
    rwr(`REG_CTRL, ctrl(1'b0, 2'h0, 4'h0, 1'b1, 3'h0));
    rwr(`REG_ADDR, 32'h2005);
    rwr(`REG_WDATA, 32'h96);
    rwr(`REG_CTRL, ctrl(1'b1, 2'h2, 4'he, 1'b1, 3'h0));
    prog_wait(1'b0);
    chk_bit(dev_par === {3'h4, 4'he, 14'h2005} && dev_data_oe, 1'b1, "write pins");
    chk_byte(dev_data_o, 8'h96, "write data");
    prog_wait(1'b1);
    chk_bit(n == 100, 1'b1, "strobe length");
    wait_idle(b);
    pread(4'hc, 14'h2005, 8'h96);
    pread(4'h0, 14'h0030, SIG_MAKER);
    pread(4'h0, 14'h0031, SIG_PART);
    pread(4'h3, 14'h0000, 8'hff);
    rwr(`REG_CTRL, ctrl(1'b1, 2'h3, 4'h1, 1'b1, 3'h0));
    prog_wait(1'b0);
    prog_wait(1'b1);
    chk_bit(n == ERASE_CYC, 1'b1, "erase strobe");
    wait_idle(b);
    pread(4'hc, 14'h2005, 8'hff);
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_serial;
    t_refuse;
    t_parallel;
    end_sim;
  end
endmodule
